// file: design/sfsb_shadow_banks.sv
// Write-only shadow banks two and three with decoded control outputs
//
// Implementation choice: the plain strobed port.
`include "sfsb_map.svh"

module sfsb_shadow_banks (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] shadow_bank_select,
   input wire logic [3:0] wr_addr,
   input wire logic [3:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [3:0] rd_data,
   output sfsb_pkg::sfsb_power_t power_ctl,
   output logic [1:0] servo_ref_sel,
   output logic mech_180mv,
   output logic text_crc_pass_only,
   output logic [1:0] laser_power_level,
   output logic pll_enable,
   output logic silence_inject,
   output logic loopback_kill,
   output logic [1:0] settling_sel,
   output logic ac_dither,
   output logic dc_dither,
   output sfsb_pkg::sfsb_diode_t offset_diode,
   output logic equalizer_enable,
   output logic [2:0] status_pin_sel,
   output sfsb_pkg::sfsb_trims_t diode_trims,
   output sfsb_pkg::sfsb_afe_t afe_ctl,
   output logic multi_write_busy
);

   function automatic logic hit(input logic [1:0] b, input logic [3:0] a,
                                input logic [1:0] wb, input logic [3:0] wa);
      hit = (b == wb) && (a == wa);
   endfunction

   sfsb_pkg::sfsb_wr_t wr;
   assign wr = '{bank: shadow_bank_select, addr: wr_addr, data: wr_data};

   logic [3:0] power_down_control;
   logic [3:0] reference_and_text_control;
   logic [3:0] laser_clock_mute_control;
   logic [3:0] settling_and_dither;
   logic [3:0] offset_diode_laser_select;
   logic [3:0] equalizer_and_status_pin;
   logic [35:0] diode_offset_trims;
   logic [15:0] analog_frontend_control;
   logic [35:0] collect;
   logic [3:0] count;
   sfsb_pkg::sfsb_state_t state;
   sfsb_pkg::sfsb_state_t next_state;

   wire in_seq = (state != sfsb_pkg::SFSB_IDLE);
   wire wr_b2_3 = wr_strobe && !in_seq && hit(wr.bank, wr.addr, `SFSB_BANK_TWO, `SFSB_ADDR_3);
   wire wr_b2_7 = wr_strobe && !in_seq && hit(wr.bank, wr.addr, `SFSB_BANK_TWO, `SFSB_ADDR_7);
   wire wr_b2_a = wr_strobe && !in_seq && hit(wr.bank, wr.addr, `SFSB_BANK_TWO, `SFSB_ADDR_A);
   wire wr_b2_c = wr_strobe && !in_seq && hit(wr.bank, wr.addr, `SFSB_BANK_TWO, `SFSB_ADDR_C);
   wire wr_b3_3 = wr_strobe && !in_seq && hit(wr.bank, wr.addr, `SFSB_BANK_THREE, `SFSB_ADDR_3);
   wire wr_b3_c = wr_strobe && !in_seq && hit(wr.bank, wr.addr, `SFSB_BANK_THREE, `SFSB_ADDR_C);
   wire start_trim = wr_strobe && !in_seq
                     && hit(wr.bank, wr.addr, `SFSB_BANK_THREE, `SFSB_ADDR_7);
   wire start_afe = wr_strobe && !in_seq
                    && hit(wr.bank, wr.addr, `SFSB_BANK_THREE, `SFSB_ADDR_A);

   // Data nibbles of a sequence follow the address write, first nibble highest
   wire data_nib = wr_strobe && in_seq;
   wire [3:0] limit = (state == sfsb_pkg::SFSB_TRIM) ? `SFSB_TRIM_NIBBLES : `SFSB_AFE_NIBBLES;
   wire last_nib = data_nib && (count == limit - 4'h1);
   wire [35:0] next_collect = {collect[31:0], wr.data};

   always_comb begin
      next_state = state;
      case (state)
         sfsb_pkg::SFSB_IDLE: begin
            if (start_trim) begin
               next_state = sfsb_pkg::SFSB_TRIM;
            end else if (start_afe) begin
               next_state = sfsb_pkg::SFSB_AFE;
            end
         end
         sfsb_pkg::SFSB_TRIM, sfsb_pkg::SFSB_AFE: begin
            if (last_nib) begin
               next_state = sfsb_pkg::SFSB_IDLE;
            end
         end
         default: next_state = sfsb_pkg::SFSB_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= sfsb_pkg::SFSB_IDLE;
         count <= 4'h0;
         collect <= 36'h0;
      end else begin
         state <= next_state;
         // Gaps between nibbles keep the partial value and the count
         if (last_nib) begin
            count <= 4'h0;
         end else if (data_nib) begin
            count <= count + 4'h1;
         end
         if (data_nib) begin
            collect <= next_collect;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         power_down_control <= `SFSB_RST_POWER;
         reference_and_text_control <= `SFSB_RST_REFTEXT;
      end else begin
         if (wr_b2_3) begin
            power_down_control <= wr.data;
         end
         if (wr_b2_7) begin
            reference_and_text_control <= wr.data;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         laser_clock_mute_control <= `SFSB_RST_LASER_CLK;
         settling_and_dither <= `SFSB_RST_SETTLE;
      end else begin
         if (wr_b2_a) begin
            laser_clock_mute_control <= wr.data;
         end
         if (wr_b2_c) begin
            settling_and_dither <= wr.data;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         offset_diode_laser_select <= `SFSB_RST_DIODE_LASER;
         equalizer_and_status_pin <= `SFSB_RST_EQ_STATUS;
      end else begin
         if (wr_b3_3) begin
            offset_diode_laser_select <= wr.data;
         end
         if (wr_b3_c) begin
            equalizer_and_status_pin <= wr.data;
         end
      end
   end

   // apply whole value only on last nibble
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         diode_offset_trims <= `SFSB_RST_TRIMS;
         analog_frontend_control <= `SFSB_RST_AFE;
      end else begin
         if (last_nib && state == sfsb_pkg::SFSB_TRIM) begin
            diode_offset_trims <= next_collect;
         end
         if (last_nib && state == sfsb_pkg::SFSB_AFE) begin
            analog_frontend_control <= next_collect[15:0];
         end
      end
   end

   // Banks are write-only; reads echo the sequencer state only
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_data <= 4'h0;
      end else begin
         rd_data <= rd_strobe ? {1'b0, state} : 4'h0;
      end
   end

   assign power_ctl.frontend_off = power_down_control[0];
   assign power_ctl.buffer_off = power_down_control[1];
   assign power_ctl.converter_off = power_down_control[2];
   assign power_ctl.converter_current_mode = power_down_control[3];
   assign servo_ref_sel = reference_and_text_control[1:0];
   assign mech_180mv = reference_and_text_control[2];
   assign text_crc_pass_only = reference_and_text_control[3];
   assign laser_power_level = {laser_clock_mute_control[0], offset_diode_laser_select[3]};
   assign pll_enable = laser_clock_mute_control[1];
   assign silence_inject = laser_clock_mute_control[2];
   assign loopback_kill = laser_clock_mute_control[3];
   assign settling_sel = settling_and_dither[1:0];
   assign ac_dither = settling_and_dither[2];
   assign dc_dither = settling_and_dither[3];

   // diode decode, unused codes fall to main one
   always_comb begin
      case (offset_diode_laser_select[2:0])
         3'h2: offset_diode = sfsb_pkg::SFSB_DIODE_MAIN2;
         3'h3: offset_diode = sfsb_pkg::SFSB_DIODE_MAIN3;
         3'h4: offset_diode = sfsb_pkg::SFSB_DIODE_MAIN4;
         3'h5: offset_diode = sfsb_pkg::SFSB_DIODE_RAD1;
         3'h6: offset_diode = sfsb_pkg::SFSB_DIODE_RAD2;
         default: offset_diode = sfsb_pkg::SFSB_DIODE_MAIN1;
      endcase
   end

   // equalizer enable in bit 0, status pin select in bits 3:1
   assign equalizer_enable = equalizer_and_status_pin[0];
   assign status_pin_sel = equalizer_and_status_pin[3:1];
   assign diode_trims = diode_offset_trims;
   assign afe_ctl = analog_frontend_control;
   assign multi_write_busy = in_seq;

endmodule // sfsb_shadow_banks

// file: design/sfsb_map.svh
// Register offsets, nibble counts, a field width, reset values and codes of the shadow banks
`ifndef SFSB_MAP_SVH
`define SFSB_MAP_SVH

`define SFSB_BANK_TWO 2'h2
`define SFSB_BANK_THREE 2'h3

`define SFSB_ADDR_3 4'h3
`define SFSB_ADDR_7 4'h7
`define SFSB_ADDR_A 4'ha
`define SFSB_ADDR_C 4'hc

`define SFSB_TRIM_NIBBLES 4'h9
`define SFSB_AFE_NIBBLES 4'h4

`define SFSB_RST_POWER 4'h0
`define SFSB_RST_REFTEXT 4'h2
`define SFSB_RST_LASER_CLK 4'h2
`define SFSB_RST_SETTLE 4'hc
`define SFSB_RST_DIODE_LASER 4'h0
`define SFSB_RST_EQ_STATUS 4'h0
`define SFSB_RST_TRIMS 36'h0
`define SFSB_RST_AFE 16'h0

`define SFSB_TRIM_W 6

`define SFSB_LASER_58 2'h0
`define SFSB_LASER_72 2'h1
`define SFSB_LASER_86 2'h2
`define SFSB_LASER_100 2'h3

`define SFSB_ST_DECODER 3'h0
`define SFSB_ST_READY 3'h1
`define SFSB_ST_VALUE 3'h2

`endif

// file: design/sfsb_pkg.sv
// Types shared by the shadow bank logic
package sfsb_pkg;

   typedef struct packed {
      logic [1:0] bank;
      logic [3:0] addr;
      logic [3:0] data;
   } sfsb_wr_t;

   typedef struct packed {
      logic frontend_off;
      logic buffer_off;
      logic converter_off;
      logic converter_current_mode;
   } sfsb_power_t;

   typedef struct packed {
      logic [5:0] trim_radial_diode_two;
      logic [5:0] trim_radial_diode_one;
      logic [5:0] trim_main_diode_four;
      logic [5:0] trim_main_diode_three;
      logic [5:0] trim_main_diode_two;
      logic [5:0] trim_main_diode_one;
   } sfsb_trims_t;

   typedef struct packed {
      logic [5:0] highpass_cutoff_code;
      logic [1:0] equalizer_rate;
      logic [3:0] slicer_slew;
      logic [3:0] frontend_gain;
   } sfsb_afe_t;

   typedef enum logic [5:0] {
      SFSB_DIODE_MAIN1 = 6'h01,
      SFSB_DIODE_MAIN2 = 6'h02,
      SFSB_DIODE_MAIN3 = 6'h04,
      SFSB_DIODE_MAIN4 = 6'h08,
      SFSB_DIODE_RAD1 = 6'h10,
      SFSB_DIODE_RAD2 = 6'h20
   } sfsb_diode_t;

   typedef enum logic [2:0] {
      SFSB_IDLE = 3'h1,
      SFSB_TRIM = 3'h2,
      SFSB_AFE = 3'h4
   } sfsb_state_t;

endpackage

// file: bench/sfsb_props.sv
// Concurrent checks on the shadow bank ports
module sfsb_props (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] shadow_bank_select,
   input wire logic [3:0] wr_addr,
   input wire logic [3:0] wr_data,
   input wire logic wr_strobe,
   input wire sfsb_pkg::sfsb_power_t power_ctl,
   input wire logic [1:0] servo_ref_sel,
   input wire logic mech_180mv,
   input wire logic text_crc_pass_only,
   input wire logic [1:0] laser_power_level,
   input wire logic pll_enable,
   input wire logic silence_inject,
   input wire logic loopback_kill,
   input wire logic [1:0] settling_sel,
   input wire logic ac_dither,
   input wire logic dc_dither,
   input wire logic equalizer_enable,
   input wire logic [2:0] status_pin_sel,
   input wire sfsb_pkg::sfsb_trims_t diode_trims,
   input wire sfsb_pkg::sfsb_afe_t afe_ctl,
   input wire logic multi_write_busy
);
   // Nibbles of a running sequence are data, not single writes
   wire logic take = wr_strobe && !multi_write_busy;
   wire logic [5:0] ba = {shadow_bank_select, wr_addr};
   logic [3:0] d_q;
   always_ff @(posedge mclk) d_q <= wr_data;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   chk_power_bits: assert property (take && ba == 6'h23 |=>
      power_ctl == {d_q[0], d_q[1], d_q[2], d_q[3]}) else $error("power bits wrong");
   chk_ref_text: assert property (take && ba == 6'h27 |=>
      {text_crc_pass_only, mech_180mv, servo_ref_sel} == d_q) else $error("reference wrong");
   chk_laser_clock: assert property (take && ba == 6'h2a |=>
      {loopback_kill, silence_inject, pll_enable, laser_power_level[1]} == d_q)
      else $error("clock or mute wrong");
   chk_settle_dither: assert property (take && ba == 6'h2c |=>
      {dc_dither, ac_dither, settling_sel} == d_q) else $error("settling wrong");
   chk_eq_status: assert property (take && ba == 6'h3c |=>
      {status_pin_sel, equalizer_enable} == d_q) else $error("status pin wrong");
   chk_bank_other: assert property (take && !shadow_bank_select[1] |=>
      $stable(power_ctl) && $stable(afe_ctl) && $stable(diode_trims)) else $error("bank leak");
   chk_multi_start: assert property (take && (ba == 6'h37 || ba == 6'h3a) |=>
      multi_write_busy) else $error("sequence not started");
   chk_multi_hold: assert property (multi_write_busy && !wr_strobe |=>
      $stable(diode_trims) && $stable(afe_ctl)) else $error("partial update");
endmodule // sfsb_props

// file: bench/sfsb_host.sv
// Host model writing shadow nibbles and reading the sequencer state
module sfsb_host (
   input wire logic mclk,
   output logic [1:0] shadow_bank_select,
   output logic [3:0] wr_addr,
   output logic [3:0] wr_data,
   output logic wr_strobe,
   output logic rd_strobe,
   input wire logic [3:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {shadow_bank_select, wr_addr, wr_data, wr_strobe, rd_strobe} = 12'h000;
   task automatic wr(input logic [1:0] b, input logic [3:0] a, input logic [3:0] d);
      @(posedge mclk);
      shadow_bank_select <= b;
      wr_addr <= a;
      wr_data <= d;
      wr_strobe <= 1'b1;
      rd_strobe <= 1'b0;
   endtask
   // Released data flips so a stale nibble never looks valid
   task automatic idle();
      @(posedge mclk);
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      wr_data <= ~wr_data;
   endtask
   task automatic rd(output logic [3:0] v);
      @(posedge mclk);
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b1;
      @(posedge mclk);
      rd_strobe <= 1'b0;
      #1;
      v = rd_data;
   endtask
   // address write, then nibbles top first down to stop
   task automatic mw(input logic [3:0] a, input int n, input logic [35:0] v, input int stop);
      wr(2'h3, a, 4'h0);
      for (int i = n - 1; i >= stop; i--) begin
         wr(2'h3, a, v[4*i +: 4]);
      end
   endtask
endmodule // sfsb_host

// file: bench/sfsb_shadow_banks_test.sv
// Self-checking bench for the shadow bank block
`define SFSB_CHK(got, exp) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         error_cnt++; \
         $display("[FAIL] %0t got %h want %h", $time, got, exp); \
      end \
   end

module sfsb_shadow_banks_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [1:0] b;
      logic [3:0] a;
      logic [3:0] d;
      logic [31:0] e;
   } sfsb_row_t;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   int error_cnt = 0;
   int total_checks = 0;
   logic [3:0] rd_val;
   wire logic [1:0] shadow_bank_select;
   wire logic [3:0] wr_addr, wr_data, rd_data;
   wire logic wr_strobe, rd_strobe;
   sfsb_pkg::sfsb_power_t power_ctl;
   sfsb_pkg::sfsb_diode_t offset_diode;
   sfsb_pkg::sfsb_trims_t diode_trims;
   sfsb_pkg::sfsb_afe_t afe_ctl;
   logic [1:0] servo_ref_sel, laser_power_level, settling_sel;
   logic [2:0] status_pin_sel;
   logic mech_180mv, text_crc_pass_only, pll_enable, silence_inject, loopback_kill;
   logic ac_dither, dc_dither, equalizer_enable, multi_write_busy;
   // One nibble per written register image; the diode register shows its laser bit and one-hot diode
   wire logic [31:0] obs = {power_ctl, text_crc_pass_only, mech_180mv, servo_ref_sel,
      loopback_kill, silence_inject, pll_enable, laser_power_level[1], dc_dither, ac_dither,
      settling_sel, status_pin_sel, equalizer_enable, laser_power_level[0], 5'h00, offset_diode};
   sfsb_row_t rows [23] = '{'{2'h2, 4'h3, 4'h7, 32'he22c0001}, '{2'h2, 4'h3, 4'h8, 32'h122c0001},
      '{2'h2, 4'h7, 4'h3, 32'h132c0001}, '{2'h2, 4'h7, 4'he, 32'h1e2c0001},
      '{2'h2, 4'ha, 4'h1, 32'h1e1c0001}, '{2'h3, 4'h3, 4'h8, 32'h1e1c0801},
      '{2'h2, 4'ha, 4'he, 32'h1eec0801}, '{2'h3, 4'h3, 4'h2, 32'h1eec0002},
      '{2'h3, 4'h3, 4'h3, 32'h1eec0004}, '{2'h3, 4'h3, 4'h4, 32'h1eec0008},
      '{2'h3, 4'h3, 4'h5, 32'h1eec0010}, '{2'h3, 4'h3, 4'h7, 32'h1eec0001},
      '{2'h3, 4'h3, 4'h6, 32'h1eec0020}, '{2'h3, 4'h3, 4'h1, 32'h1eec0001},
      '{2'h2, 4'hc, 4'h4, 32'h1ee40001}, '{2'h2, 4'hc, 4'h9, 32'h1ee90001},
      '{2'h2, 4'hc, 4'h2, 32'h1ee20001}, '{2'h2, 4'hc, 4'hf, 32'h1eef0001},
      '{2'h3, 4'hc, 4'h3, 32'h1eef3001}, '{2'h3, 4'hc, 4'h4, 32'h1eef4001},
      '{2'h1, 4'h3, 4'h0, 32'h1eef4001}, '{2'h0, 4'h7, 4'h0, 32'h1eef4001},
      '{2'h2, 4'h5, 4'h0, 32'h1eef4001}};
   always #10 mclk = ~mclk;
   sfsb_host u_host (.*);
   sfsb_shadow_banks dut (.*);
   task automatic wrap_up();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (1000) @(posedge mclk);
      error_cnt++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      #1;
      `SFSB_CHK({obs, multi_write_busy, diode_trims, afe_ctl}, {32'h022c0001, 53'h0})
      u_host.rd(rd_val);
      `SFSB_CHK(rd_val, 4'h1)
      foreach (rows[i]) begin
         u_host.wr(rows[i].b, rows[i].a, rows[i].d);
         u_host.idle();
         #1;
         `SFSB_CHK(obs, rows[i].e)
      end
      u_host.mw(4'h7, 9, 36'hfedcba987, 1);
      u_host.rd(rd_val);
      `SFSB_CHK({rd_val, multi_write_busy, diode_trims}, {4'h2, 1'b1, 36'h0})
      // Next sequence starts on the edge after the last nibble
      u_host.wr(2'h3, 4'h7, 4'h7);
      u_host.mw(4'ha, 4, 36'h9abc, 0);
      u_host.idle();
      #1;
      `SFSB_CHK({multi_write_busy, diode_trims}, {1'b0, 36'hfedcba987})
      `SFSB_CHK({diode_trims.trim_main_diode_one, diode_trims.trim_radial_diode_two}, 12'h1ff)
      `SFSB_CHK(afe_ctl, 16'h9abc)
      `SFSB_CHK({afe_ctl.frontend_gain, afe_ctl.slicer_slew, afe_ctl.equalizer_rate}, 10'h32e)
      u_host.mw(4'h7, 9, 36'h123456789, 6);
      rst <= 1'b1;
      u_host.idle();
      rst <= 1'b0;
      #1;
      `SFSB_CHK({obs, multi_write_busy, diode_trims, afe_ctl}, {32'h022c0001, 53'h0})
      u_host.wr(2'h2, 4'h3, 4'h1);
      u_host.idle();
      #1;
      `SFSB_CHK(obs, 32'h822c0001)
      wrap_up();
   end
endmodule // sfsb_shadow_banks_test

bind sfsb_shadow_banks sfsb_props u_props (.*);
